// ### src/csrp_port.sv
// smbus slave port and register map of the charge controller
`timescale 1ns/1ns
module csrp_port
  import csrp_pkg::*;
#(
  parameter logic [15:0] PART_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h005A, // arbitrary value
  parameter longint WDT_CYC1 = CSRP_WDT_C1,
  parameter longint WDT_CYC2 = CSRP_WDT_C2,
  parameter longint WDT_CYC3 = CSRP_WDT_C3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] cell_count_sense_pin,
  input wire logic current_limit_highz_pin,
  input wire csrp_fault_type fault_in,
  input wire logic [15:0] charger_state_flags,
  input wire logic [15:0] throttle_event_in,
  input wire logic [15:0] effective_input_current_limit,
  input wire logic [15:0] input_voltage_system_power_reading,
  input wire logic [15:0] battery_current_reading,
  input wire logic [15:0] input_current_comparator_reading,
  input wire logic [15:0] system_battery_voltage_reading,
  output csrp_bridge_type bridge_out,
  output logic pass_through_mode,
  output logic charge_enable
);

  // ----------------------------------------
  // bus condition detection
  // ----------------------------------------
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end
  assign scl_rise = scl_in & ~scl_d_reg; // R8
  assign scl_fall = ~scl_in & scl_d_reg;
  assign start_det = scl_in & scl_d_reg & sda_d_reg & ~sda_in; // R5
  assign stop_det = scl_in & scl_d_reg & ~sda_d_reg & sda_in; // R5

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [15:0] opt0_reg, cur_reg, volt_reg, opt1_reg, opt2_reg, opt3_reg;
  logic [15:0] thr0_reg, thr1_reg, adco_reg, opt4_reg, rvv_reg, rvc_reg;
  logic [15:0] vin_reg, vmin_reg, iin_reg, thr_stat_reg;
  logic wr_stb, rd_done;
  logic [7:0] cmd_reg;
  logic [15:0] wdata_reg;
  logic wdt_expire;
  logic cell_seen_reg;

  function automatic logic [15:0] cell_default(input logic [2:0] cells);
    int mv;
    mv = CSRP_CELL_MV * int'(cells) / CSRP_VOLT_LSB_MV;
    return 16'(mv * CSRP_VOLT_LSB_MV);
  endfunction

  function automatic logic [15:0] read_mux(input logic [7:0] c,
      input logic [15:0] ts);
    case (c)
      CSRP_OPT0: read_mux = opt0_reg;
      CSRP_CHG_CUR: read_mux = cur_reg;
      CSRP_CHG_VOLT: read_mux = volt_reg;
      CSRP_STATE: read_mux = charger_state_flags;
      CSRP_THR_STAT: read_mux = ts;
      CSRP_IIN_EFF: read_mux = effective_input_current_limit;
      CSRP_ADC_VBUS: read_mux = input_voltage_system_power_reading;
      CSRP_ADC_IBAT: read_mux = battery_current_reading;
      CSRP_ADC_IIN: read_mux = input_current_comparator_reading;
      CSRP_ADC_VSYS: read_mux = system_battery_voltage_reading;
      CSRP_OPT1: read_mux = opt1_reg;
      CSRP_OPT2: read_mux = opt2_reg;
      CSRP_OPT3: read_mux = opt3_reg;
      CSRP_THR_OPT0: read_mux = thr0_reg;
      CSRP_THR_OPT1: read_mux = thr1_reg;
      CSRP_ADC_OPT: read_mux = adco_reg;
      CSRP_OPT4: read_mux = opt4_reg;
      CSRP_REV_VOLT: read_mux = rvv_reg;
      CSRP_REV_CUR: read_mux = rvc_reg;
      CSRP_VIN_LIM: read_mux = vin_reg;
      CSRP_VSYS_MIN: read_mux = vmin_reg;
      CSRP_HOST_INPUT_CURRENT_LIMIT: read_mux = iin_reg;
      CSRP_MAKER: read_mux = MAKER_CODE; // R13
      CSRP_PART: read_mux = PART_CODE; // R13
      default: read_mux = CSRP_ZERO_RST; // R23
    endcase
  endfunction

  // ----------------------------------------
  // smbus slave state machine
  // ----------------------------------------
  csrp_state_type st_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [1:0] byte_reg;
  logic rd_mode_reg, nack_reg, drive_reg;
  logic [15:0] rdata_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= CSRP_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      byte_reg <= 2'h0;
      rd_mode_reg <= 1'b0;
      nack_reg <= 1'b0;
      drive_reg <= 1'b0;
      cmd_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      wr_stb <= 1'b0;
      rd_done <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_done <= 1'b0;
      if (stop_det) begin
        st_reg <= CSRP_IDLE; // R5
        drive_reg <= 1'b0;
      end else if (start_det) begin
        st_reg <= CSRP_ADDR; // R5
        bit_reg <= 4'h0;
        drive_reg <= 1'b0;
      end else begin
        case (st_reg)
          CSRP_IDLE: begin
          end
          CSRP_ADDR, CSRP_RXB: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_in}; // R7
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (st_reg == CSRP_ADDR) begin
                if (sh_reg[7:1] == CSRP_SLAVE_ADDR) begin // R1
                  rd_mode_reg <= sh_reg[0]; // R12
                  byte_reg <= 2'h0;
                  drive_reg <= 1'b1;
                  st_reg <= CSRP_ACK;
                  rdata_reg <= read_mux(cmd_reg, thr_stat_reg);
                end else begin
                  st_reg <= CSRP_SKIP; // R1
                end
              end else begin
                drive_reg <= 1'b1; // R9
                st_reg <= CSRP_ACK;
                case (byte_reg)
                  2'h1: cmd_reg <= sh_reg;
                  2'h2: wdata_reg[7:0] <= sh_reg; // R22
                  default: wdata_reg[15:8] <= sh_reg; // R22
                endcase
              end
            end
          end
          CSRP_ACK: begin
            if (scl_fall) begin // R6
              drive_reg <= 1'b0;
              if (rd_mode_reg) begin
                sh_reg <= rdata_reg[7:0]; // R4
                drive_reg <= 1'b1;
                st_reg <= CSRP_TXB;
              end else if (byte_reg == 2'h3) begin // R3
                wr_stb <= 1'b1; // R22
                st_reg <= CSRP_SKIP; // R10
              end else begin
                byte_reg <= byte_reg + 2'h1;
                st_reg <= CSRP_RXB;
              end
            end
          end
          CSRP_TXB: begin
            if (scl_rise) begin
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall) begin
              sh_reg <= {sh_reg[6:0], 1'b0}; // R7
              if (bit_reg == 4'h8) begin
                drive_reg <= 1'b0;
                bit_reg <= 4'h0;
                st_reg <= CSRP_MACK;
              end
            end
          end
          CSRP_MACK: begin
            if (scl_rise) begin
              nack_reg <= sda_in; // R12
            end
            if (scl_fall) begin
              if (nack_reg || byte_reg == 2'h1) begin
                rd_done <= 1'b1; // R11
                st_reg <= CSRP_SKIP;
              end else begin
                byte_reg <= 2'h1;
                sh_reg <= rdata_reg[15:8]; // R4
                drive_reg <= 1'b1;
                st_reg <= CSRP_TXB;
              end
            end
          end
          CSRP_SKIP: begin
          end
          default: st_reg <= CSRP_IDLE;
        endcase
      end
    end
  end

  // open-drain: only ever pulls low, never starts a transfer
  always_comb begin
    sda_out = 1'b0; // R2
    if (st_reg == CSRP_TXB) begin
      sda_oe = drive_reg & ~sh_reg[7];
    end else begin
      sda_oe = drive_reg; // R12
    end
  end

  // ----------------------------------------
  // register writes and watchdog
  // ----------------------------------------
  logic wr_ok;
  logic wdt_hit;
  logic [1:0] wdt_sel;
  longint wdt_lim;
  logic [31:0] wdt_cnt_reg;
  assign wr_ok = wr_stb;
  assign wdt_sel = opt0_reg[CSRP_WDT_HI:CSRP_WDT_LO];
  assign wdt_hit = wr_ok && (cmd_reg == CSRP_CHG_CUR ||
    cmd_reg == CSRP_CHG_VOLT || cmd_reg == CSRP_OPT0);
  always_comb begin
    case (wdt_sel)
      2'b01: wdt_lim = WDT_CYC1;
      2'b10: wdt_lim = WDT_CYC2;
      default: wdt_lim = WDT_CYC3;
    endcase
  end
  assign wdt_expire = (wdt_sel != 2'b00) &&
    (longint'(wdt_cnt_reg) >= wdt_lim - 1); // R20

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdt_cnt_reg <= 32'h0;
    end else if (wdt_hit || wdt_expire || wdt_sel == 2'b00) begin
      wdt_cnt_reg <= 32'h0; // R20
    end else begin
      wdt_cnt_reg <= wdt_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      opt0_reg <= CSRP_OPT0_RST;
      cur_reg <= CSRP_ZERO_RST;
      volt_reg <= CSRP_ZERO_RST;
      opt1_reg <= CSRP_ZERO_RST;
      opt2_reg <= CSRP_ZERO_RST;
      opt3_reg <= CSRP_ZERO_RST;
      thr0_reg <= CSRP_ZERO_RST;
      thr1_reg <= CSRP_ZERO_RST;
      adco_reg <= CSRP_ZERO_RST;
      opt4_reg <= CSRP_ZERO_RST;
      rvv_reg <= CSRP_ZERO_RST;
      rvc_reg <= CSRP_ZERO_RST;
      vin_reg <= CSRP_ZERO_RST;
      vmin_reg <= CSRP_ZERO_RST;
      iin_reg <= CSRP_ZERO_RST;
      cell_seen_reg <= 1'b0;
    end else begin
      if (!cell_seen_reg) begin
        cell_seen_reg <= 1'b1;
        volt_reg <= cell_default(cell_count_sense_pin); // R14
      end
      if (wdt_expire) begin
        cur_reg <= CSRP_ZERO_RST; // R20
      end
      if (wr_ok) begin
        case (cmd_reg) // R23
          CSRP_OPT0: opt0_reg <= wdata_reg;
          CSRP_CHG_CUR: cur_reg <= wdata_reg;
          CSRP_CHG_VOLT: volt_reg <= wdata_reg;
          CSRP_OPT1: opt1_reg <= wdata_reg;
          CSRP_OPT2: opt2_reg <= wdata_reg;
          CSRP_OPT3: opt3_reg <= wdata_reg;
          CSRP_THR_OPT0: thr0_reg <= wdata_reg;
          CSRP_THR_OPT1: thr1_reg <= wdata_reg;
          CSRP_ADC_OPT: adco_reg <= wdata_reg;
          CSRP_OPT4: opt4_reg <= wdata_reg;
          CSRP_REV_VOLT: rvv_reg <= wdata_reg;
          CSRP_REV_CUR: rvc_reg <= wdata_reg;
          CSRP_VIN_LIM: vin_reg <= wdata_reg;
          CSRP_VSYS_MIN: vmin_reg <= wdata_reg;
          CSRP_HOST_INPUT_CURRENT_LIMIT: iin_reg <= wdata_reg;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // throttle status flags
  // ----------------------------------------
  logic thr_rd;
  logic [15:0] keep_mask;
  assign thr_rd = rd_done && cmd_reg == CSRP_THR_STAT;
  always_comb begin
    keep_mask = 16'h0000;
    keep_mask[CSRP_VDPM_BIT] = 1'b1;
    keep_mask[CSRP_VAP_BIT] = 1'b1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      thr_stat_reg <= 16'h0000;
    end else begin
      // new events win over clears
      if (thr_rd) begin
        thr_stat_reg <= (thr_stat_reg & keep_mask) | throttle_event_in; // R21
      end else if (wr_ok && cmd_reg == CSRP_THR_STAT) begin
        thr_stat_reg <= (thr_stat_reg & (wdata_reg | ~keep_mask)) |
          throttle_event_in;
      end else begin
        thr_stat_reg <= thr_stat_reg | throttle_event_in;
      end
    end
  end

  // ----------------------------------------
  // charge and pass-through control
  // ----------------------------------------
  logic ptm_reg, ptm_ok, fault_any;
  assign fault_any = |fault_in; // R19
  assign ptm_ok = ~opt3_reg[CSRP_EXTILIM_BIT] & opt3_reg[CSRP_PTM_PIN_BIT] &
    opt3_reg[CSRP_PTM_EN_BIT] & ~current_limit_highz_pin; // R17
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptm_reg <= 1'b0;
    end else if (fault_any || !ptm_ok) begin
      ptm_reg <= 1'b0; // R18
    end else begin
      ptm_reg <= 1'b1; // R17
    end
  end
  assign pass_through_mode = ptm_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bridge_out <= '0;
      charge_enable <= 1'b0;
    end else begin
      bridge_out <= ptm_reg ? 5'b11000 : 5'b00001; // R16
      charge_enable <= ~opt0_reg[CSRP_INHIBIT_BIT] &&
        (cur_reg != 16'h0000) && !ptm_reg; // R15
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ptm_exit_fault: assert property (@(posedge clk_sys) disable iff (rst)
    fault_any |=> !ptm_reg) else $error("ptm held under fault"); // R19
  a_ptm_entry: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ptm_reg) |-> $past(ptm_ok)) else $error("bad ptm entry"); // R17
  a_ptm_pin: assert property (@(posedge clk_sys) disable iff (rst)
    current_limit_highz_pin |=> !ptm_reg) else $error("pin ignored"); // R18
  a_bridge_ptm: assert property (@(posedge clk_sys) disable iff (rst)
    ptm_reg |=> bridge_out == 5'b11000) else $error("bridge bad"); // R16
  a_charge_stop: assert property (@(posedge clk_sys) disable iff (rst)
    cur_reg == 16'h0000 |=> !charge_enable) else $error("charging"); // R15
  a_wdt_clear: assert property (@(posedge clk_sys) disable iff (rst)
    wdt_expire && !wr_ok |=> cur_reg == 16'h0000)
    else $error("watchdog missed"); // R20
  a_no_start: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg == CSRP_IDLE |-> !sda_oe) else $error("drives idle"); // R2
  a_ack_addr: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg == CSRP_ADDR && scl_fall && bit_reg == 4'h8 &&
    sh_reg[7:1] != CSRP_SLAVE_ADDR |=> st_reg == CSRP_SKIP)
    else $error("foreign address acked"); // R1
  a_sda_stable: assert property (@(posedge clk_sys) disable iff (rst)
    scl_in && scl_d_reg && st_reg == CSRP_TXB |-> $stable(sda_oe))
    else $error("sda moved with scl high"); // R6
  a_vdpm_keep: assert property (@(posedge clk_sys) disable iff (rst)
    thr_rd && thr_stat_reg[CSRP_VDPM_BIT] |=> thr_stat_reg[CSRP_VDPM_BIT])
    else $error("vdpm cleared by read"); // R21
  c_write: cover property (@(posedge clk_sys) wr_stb);
  c_read: cover property (@(posedge clk_sys) rd_done);
  c_ptm: cover property (@(posedge clk_sys) $rose(ptm_reg));
  c_wdt: cover property (@(posedge clk_sys) wdt_expire);
endmodule

// ### include/csrp_pkg.sv
// package for the charger smbus register port
// Behaviour
// R1: slave only, answers address 0x09, ignores all other addresses
// R2: never drives a start or stop; master begins and ends transfers
// R3: only word-write and word-read formats reach registers
// R4: every register is 16 bits, moved as low byte then high byte
// R5: start is sda falling with scl high; stop is sda rising with scl high
// R6: sda changes only while scl is low outside start and stop
// R7: bytes are eight bits, most significant bit first
// R8: receiver captures sda on rising scl
// R9: ninth bit of each byte is an acknowledge from the receiver
// R10: write word: addr+w, cmd, low, high, each acked by slave, stop
// R11: read word: addr+w, cmd, restart, addr+r, low acked, high nacked
// R12: write bit and ack are low; read bit and nack are high
// R13: read-only maker code at 0xFE and part code at 0xFF
// R14: at start-up load 4.2 V per cell from the cell-count pin
// R15: charging stops on suppress bit set or charge current zero
// R16: pass-through holds uppers on, lowers off, no switching
// R17: pass-through entry needs ext limit 0, pin select 1, enable 1, pin low
// R18: pass-through leaves when enable written 0 or highz pin high
// R19: pass-through leaves on any fault or input voltage limiting
// R20: watchdog expiry without voltage or current write clears current; a CSRP_OPT0 write also restarts the timer here
// R21: throttle flags clear on read if event gone, except two flags
// R22: first byte is bits 7:0, second 15:8; update after high ack
// R23: unmapped reads give zero; read-only or unmapped writes ignored
package csrp_pkg;
  localparam logic [6:0] CSRP_SLAVE_ADDR = 7'h09;
  localparam logic [7:0] CSRP_OPT0 = 8'h12;
  localparam logic [7:0] CSRP_CHG_CUR = 8'h14;
  localparam logic [7:0] CSRP_CHG_VOLT = 8'h15;
  localparam logic [7:0] CSRP_STATE = 8'h20;
  localparam logic [7:0] CSRP_THR_STAT = 8'h21;
  localparam logic [7:0] CSRP_IIN_EFF = 8'h22;
  localparam logic [7:0] CSRP_ADC_VBUS = 8'h23;
  localparam logic [7:0] CSRP_ADC_IBAT = 8'h24;
  localparam logic [7:0] CSRP_ADC_IIN = 8'h25;
  localparam logic [7:0] CSRP_ADC_VSYS = 8'h26;
  localparam logic [7:0] CSRP_OPT1 = 8'h30;
  localparam logic [7:0] CSRP_OPT2 = 8'h31;
  localparam logic [7:0] CSRP_OPT3 = 8'h32;
  localparam logic [7:0] CSRP_THR_OPT0 = 8'h33;
  localparam logic [7:0] CSRP_THR_OPT1 = 8'h34;
  localparam logic [7:0] CSRP_ADC_OPT = 8'h35;
  localparam logic [7:0] CSRP_OPT4 = 8'h36;
  localparam logic [7:0] CSRP_REV_VOLT = 8'h3B;
  localparam logic [7:0] CSRP_REV_CUR = 8'h3C;
  localparam logic [7:0] CSRP_VIN_LIM = 8'h3D;
  localparam logic [7:0] CSRP_VSYS_MIN = 8'h3E;
  localparam logic [7:0] CSRP_HOST_INPUT_CURRENT_LIMIT = 8'h3F;
  localparam logic [7:0] CSRP_MAKER = 8'hFE;
  localparam logic [7:0] CSRP_PART = 8'hFF;
  // register reset values
  localparam logic [15:0] CSRP_OPT0_RST = 16'hE70E;
  localparam logic [15:0] CSRP_ZERO_RST = 16'h0000;
  // per-cell default voltage in millivolts, register lsb in millivolts
  localparam int CSRP_CELL_MV = 4200;
  localparam int CSRP_VOLT_LSB_MV = 8;
  // field positions
  localparam int CSRP_WDT_HI = 14;
  localparam int CSRP_WDT_LO = 13;
  localparam int CSRP_INHIBIT_BIT = 0;
  localparam int CSRP_PTM_EN_BIT = 1;
  localparam int CSRP_PTM_PIN_BIT = 2;
  localparam int CSRP_EXTILIM_BIT = 7;
  localparam int CSRP_VDPM_BIT = 7;
  localparam int CSRP_VAP_BIT = 8;
  // watchdog periods in seconds
  localparam longint CSRP_CLK_HZ = 25000000;
  localparam longint CSRP_WDT_S1 = 5;
  localparam longint CSRP_WDT_S2 = 77;
  localparam longint CSRP_WDT_S3 = 153;
  localparam longint CSRP_WDT_C1 = CSRP_WDT_S1 * CSRP_CLK_HZ;
  localparam longint CSRP_WDT_C2 = CSRP_WDT_S2 * CSRP_CLK_HZ;
  localparam longint CSRP_WDT_C3 = CSRP_WDT_S3 * CSRP_CLK_HZ;

  typedef enum logic [2:0] {
    CSRP_IDLE = 3'b000,
    CSRP_ADDR = 3'b001,
    CSRP_ACK = 3'b010,
    CSRP_RXB = 3'b011,
    CSRP_TXB = 3'b100,
    CSRP_MACK = 3'b101,
    CSRP_SKIP = 3'b110
  } csrp_state_type;

  typedef struct packed {
    logic input_overcurrent;
    logic thermal_shutdown_event;
    logic battery_discharge_overcurrent;
    logic battery_overvoltage;
    logic input_voltage_power_limiting;
  } csrp_fault_type;

  typedef struct packed {
    logic upper_a_on;
    logic upper_b_on;
    logic lower_a_on;
    logic lower_b_on;
    logic switching_en;
  } csrp_bridge_type;
endpackage

// ### test/csrp_host_model.sv
// smbus host master model driving word transfers
`timescale 1ns/1ns
module csrp_host_model
  import csrp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // scl half period in system clocks
  localparam int HALF = 4;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // --------------------------------------------------------------
  // bit level
  // --------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // data set while scl low, sampled late in scl high
  task automatic bit_cycle(input logic b, output logic got);
    tick(1);
    sda_pull = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    got = sda_line;
    scl = 1'b0;
  endtask

  // start or repeated start, master only
  task automatic start_cond();
    tick(1);
    sda_pull = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(1);
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b0;
    tick(HALF);
  endtask

  // --------------------------------------------------------------
  // byte level
  // --------------------------------------------------------------
  task automatic send_byte(input logic [7:0] d, output logic nk);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], g);
    end
    bit_cycle(1'b1, nk);
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(last, g);
  endtask

  // --------------------------------------------------------------
  // word transfers
  // --------------------------------------------------------------
  task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                            input logic [15:0] v, output logic [3:0] nk);
    start_cond();
    send_byte({a, 1'b0}, nk[3]);
    send_byte(c, nk[2]);
    send_byte(v[7:0], nk[1]);
    send_byte(v[15:8], nk[0]);
    stop_cond();
  endtask

  task automatic read_word(input logic [6:0] a, input logic [7:0] c,
                           output logic [15:0] v, output logic [2:0] nk);
    start_cond();
    send_byte({a, 1'b0}, nk[2]);
    send_byte(c, nk[1]);
    start_cond();
    send_byte({a, 1'b1}, nk[0]);
    recv_byte(1'b0, v[7:0]);
    recv_byte(1'b1, v[15:8]);
    stop_cond();
  endtask
endmodule

// ### test/csrp_port_tb.sv
// self-checking bench for the charger smbus register port
`timescale 1ns/1ns
module csrp_port_tb
  import csrp_pkg::*;
;
  localparam int CELLS = 3;
  localparam logic [15:0] MAKER = 16'h0C3C; // arbitrary value
  localparam logic [15:0] PART = 16'h0E1E; // arbitrary value
  localparam logic [7:0] RW_LIST [11] = '{CSRP_OPT1, CSRP_OPT2,
    CSRP_THR_OPT0, CSRP_THR_OPT1, CSRP_ADC_OPT, CSRP_OPT4, CSRP_REV_VOLT,
    CSRP_REV_CUR, CSRP_VIN_LIM, CSRP_VSYS_MIN, CSRP_HOST_INPUT_CURRENT_LIMIT};
  localparam logic [7:0] RO_LIST [6] = '{CSRP_STATE, CSRP_IIN_EFF,
    CSRP_ADC_VBUS, CSRP_ADC_IBAT, CSRP_ADC_IIN, CSRP_ADC_VSYS};
  logic clk_sys, rst, scl, sda_pull, sda_out, sda_oe, sda_line;
  logic current_limit_highz_pin, pass_through_mode, charge_enable;
  logic [2:0] cell_count_sense_pin;
  logic [15:0] throttle_event_in;
  logic [15:0] ro_val [6];
  logic [3:0] nk;
  csrp_fault_type fault_in;
  csrp_bridge_type bridge_out;
  int miscompares;
  int samples_checked;

  // wired-and of both open-drain parties with pull-up
  assign sda_line = !(sda_pull || (sda_oe && !sda_out));

  csrp_port #(.PART_CODE(PART), .MAKER_CODE(MAKER), .WDT_CYC1(2000),
    .WDT_CYC2(40000), .WDT_CYC3(60000)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .cell_count_sense_pin(cell_count_sense_pin),
    .current_limit_highz_pin(current_limit_highz_pin),
    .fault_in(fault_in), .charger_state_flags(ro_val[0]),
    .throttle_event_in(throttle_event_in),
    .effective_input_current_limit(ro_val[1]),
    .input_voltage_system_power_reading(ro_val[2]),
    .battery_current_reading(ro_val[3]),
    .input_current_comparator_reading(ro_val[4]),
    .system_battery_voltage_reading(ro_val[5]),
    .bridge_out(bridge_out), .pass_through_mode(pass_through_mode),
    .charge_enable(charge_enable));

  csrp_host_model u_host (.clk_sys(clk_sys), .sda_line(sda_line),
    .scl(scl), .sda_pull(sda_pull));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    logic [3:0] k;
    u_host.write_word(CSRP_SLAVE_ADDR, c, v, k);
    check16("write ack", 16'h0000, {12'h000, k});
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] d;
    logic [2:0] k;
    u_host.read_word(CSRP_SLAVE_ADDR, c, d, k);
    check16("read ack", 16'h0000, {13'h0000, k});
    check16($sformatf("register %h", c), exp, d);
  endtask

  task automatic expect_ptm(input logic p);
    step(4);
    check16("pass through", {15'h0000, p}, {15'h0000, pass_through_mode});
    check16("bridge", p ? 16'h0018 : 16'h0001, {11'h000, bridge_out});
  endtask

  task automatic expect_chg(input logic e);
    step(4);
    check16("charge enable", {15'h0000, e}, {15'h0000, charge_enable});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    $display("MISMATCH run length expected end seen limit");
    stop_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    current_limit_highz_pin = 1'b0;
    cell_count_sense_pin = 3'(CELLS);
    throttle_event_in = 16'h0000;
    fault_in = '0;
    for (int i = 0; i < 6; i++) begin
      ro_val[i] = 16'(16'h1111 * (i + 1));
    end
    miscompares = 0;
    samples_checked = 0;
    step(10);
    rst = 1'b0;
    step(2);
    rd(CSRP_CHG_VOLT, 16'(CELLS * CSRP_CELL_MV));
    rd(CSRP_OPT0, CSRP_OPT0_RST);
    rd(CSRP_MAKER, MAKER);
    rd(CSRP_PART, PART);
    rd(8'h13, 16'h0000);
    wr(CSRP_MAKER, 16'hFFFF);
    rd(CSRP_MAKER, MAKER);
    $display("test defaults done");
    foreach (RW_LIST[i]) wr(RW_LIST[i], {~RW_LIST[i], RW_LIST[i]});
    foreach (RW_LIST[i]) rd(RW_LIST[i], {~RW_LIST[i], RW_LIST[i]});
    wr(RO_LIST[0], 16'hFFFF);
    foreach (RO_LIST[i]) rd(RO_LIST[i], ro_val[i]);
    u_host.write_word(7'h0A, CSRP_OPT1, 16'h0000, nk);
    check16("foreign nack", 16'h000F, {12'h000, nk});
    rd(CSRP_OPT1, {~CSRP_OPT1, CSRP_OPT1});
    $display("test register access done");
    expect_chg(1'b0);
    wr(CSRP_CHG_CUR, 16'h0100);
    expect_chg(1'b1);
    wr(CSRP_OPT0, CSRP_OPT0_RST | 16'h0001);
    expect_chg(1'b0);
    wr(CSRP_OPT0, CSRP_OPT0_RST);
    expect_chg(1'b1);
    wr(CSRP_CHG_CUR, 16'h0000);
    expect_chg(1'b0);
    $display("test charge control done");
    wr(CSRP_OPT3, 16'h0086);
    expect_ptm(1'b0);
    wr(CSRP_OPT3, 16'h0002);
    expect_ptm(1'b0);
    wr(CSRP_OPT3, 16'h0006);
    expect_ptm(1'b1);
    current_limit_highz_pin = 1'b1;
    expect_ptm(1'b0);
    current_limit_highz_pin = 1'b0;
    expect_ptm(1'b1);
    for (int i = 0; i < 5; i++) begin
      fault_in = csrp_fault_type'(5'b00001 << i);
      expect_ptm(1'b0);
      fault_in = '0;
      expect_ptm(1'b1);
    end
    wr(CSRP_OPT3, 16'h0004);
    expect_ptm(1'b0);
    $display("test pass through done");
    throttle_event_in = 16'h0081;
    step(2);
    throttle_event_in = 16'h0000;
    rd(CSRP_THR_STAT, 16'h0081);
    rd(CSRP_THR_STAT, 16'h0080);
    $display("test throttle flags done");
    wr(CSRP_OPT0, 16'h870E);
    wr(CSRP_CHG_CUR, 16'h0100);
    step(2500);
    rd(CSRP_CHG_CUR, 16'h0100);
    wr(CSRP_OPT0, 16'hA70E);
    wr(CSRP_CHG_CUR, 16'h0100);
    step(1500);
    rd(CSRP_CHG_CUR, 16'h0100);
    step(1000);
    rd(CSRP_CHG_CUR, 16'h0000);
    rd(CSRP_OPT0, 16'hA70E);
    expect_chg(1'b0);
    $display("test watchdog done");
    stop_test();
  end
endmodule
